// ---- tb_top.sv ----
// Self-checking bench for the 8-bit dual compare timer core.
// Assumes tmr_pkg and tmr_core are compiled first; bench is bus master.
`timescale 1ns/1ps
module tb_top;
   import tmr_pkg::*;
   logic        clk_i;
   logic        nrst_i;
   logic        wb_cyc_i;
   logic        wb_stb_i;
   logic        wb_we_i;
   logic [7:0]  wb_adr_i;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        ext_count_pin_i;
   logic        ovf_serviced_i;
   logic        match_a_serviced_i;
   logic        match_b_serviced_i;
   logic        ovf_irq_o;
   logic        match_a_irq_o;
   logic        match_b_irq_o;
   logic        wave_out_a_o;
   logic        wave_out_b_o;
   int          n_fail;
   int          compares;
   logic [31:0] q;
   logic        w0;
   logic [1:0]  act_tab [4] = '{TMR_OA_SET, TMR_OA_NONE, TMR_OA_CLEAR,
                                TMR_OA_TOGGLE};
   logic        exp_tab [4] = '{1'b1, 1'b1, 1'b0, 1'b1};

   tmr_core tmr_core_inst (.clk_i(clk_i), .nrst_i(nrst_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .ext_count_pin_i(ext_count_pin_i), .ovf_serviced_i(ovf_serviced_i),
      .match_a_serviced_i(match_a_serviced_i),
      .match_b_serviced_i(match_b_serviced_i), .ovf_irq_o(ovf_irq_o),
      .match_a_irq_o(match_a_irq_o), .match_b_irq_o(match_b_irq_o),
      .wave_out_a_o(wave_out_a_o), .wave_out_b_o(wave_out_b_o));

   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   // Single classic cycle; read data taken only at the ack edge
   task automatic wb_xfer(input logic we, input logic [7:0] adr,
                          input logic [7:0] d, output logic [31:0] rd);
      int n;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= 4'hF;
      wb_dat_i <= {24'h000000, d};
      for (n = 0; n < 20; n++) begin
         @(posedge clk_i);
         if (wb_ack_o === 1'b1) break;
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      if (n == 20) begin
         n_fail++;
         end_of_test();
      end
   endtask : wb_xfer

   task automatic wr(input logic [7:0] adr, input logic [7:0] d);
      logic [31:0] dummy;
      wb_xfer(1'b1, adr, d, dummy);
   endtask : wr

   task automatic rd(input logic [7:0] adr, output logic [31:0] v);
      wb_xfer(1'b0, adr, 8'h00, v);
   endtask : rd

   // Bounded wait for an interrupt line: 0 overflow, 1 match A
   task automatic wait_irq(input int sel);
      int n;
      for (n = 0; n < 300; n++) begin
         @(posedge clk_i);
         if ((sel == 0 ? ovf_irq_o : match_a_irq_o) === 1'b1) break;
      end
      if (n == 300) begin
         n_fail++;
         end_of_test();
      end
   endtask : wait_irq

   initial begin
      n_fail = 0;
      compares = 0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h00000000;
      {ext_count_pin_i, ovf_serviced_i} = 2'h0;
      {match_a_serviced_i, match_b_serviced_i} = 2'h0;
      nrst_i = 1'b0;
      repeat (5) @(posedge clk_i);
      nrst_i <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rd(8'(i * 4), q);
         check(q, 32'h00000000);
      end
      rd(8'h18, q);
      check(q, 32'h00000000);
      rd(8'h40, q);
      check(q, 32'h00000000);
      check({wave_out_a_o, wave_out_b_o}, 32'h0);
      wr(TMR_OFS_POWER, 8'h00);
      // Forced matches in normal mode, timer stopped
      for (int i = 0; i < 4; i++) begin
         wr(TMR_OFS_CTRL_A, {act_tab[i], 6'h00});
         wr(TMR_OFS_CTRL_B, 8'h80);
         repeat (3) @(posedge clk_i);
         check(wave_out_a_o, exp_tab[i]);
      end
      check(wave_out_b_o, 1'b0);
      rd(TMR_OFS_FLAG, q);
      check(q, 32'h00000000);
      rd(TMR_OFS_COUNT, q);
      check(q, 32'h00000000);
      wr(TMR_OFS_CTRL_A, 8'h00);
      wr(TMR_OFS_CMP_A, 8'hA5);
      rd(TMR_OFS_CMP_A, q);
      check(q, 32'h000000A5);
      // Counter parked on compare B; first tick must not match
      wr(TMR_OFS_CMP_B, 8'h20);
      wr(TMR_OFS_MASK, 8'h04);
      wr(TMR_OFS_COUNT, 8'h20);
      repeat (4) @(posedge clk_i);
      rd(TMR_OFS_COUNT, q);
      check(q, 32'h00000020);
      wr(TMR_OFS_CTRL_B, {5'h00, TMR_CS_D1});
      wr(TMR_OFS_CTRL_B, 8'h00);
      rd(TMR_OFS_FLAG, q);
      check(q[TMR_FL_MB], 1'b0);
      // Three ticks from 0x1F: match at 0x20, flag one tick later
      wr(TMR_OFS_COUNT, 8'h1F);
      wr(TMR_OFS_CTRL_B, {5'h00, TMR_CS_D1});
      wr(TMR_OFS_CTRL_B, 8'h00);
      check(match_b_irq_o, 1'b1);
      // Normal mode wrap and overflow
      wr(TMR_OFS_COUNT, 8'hF0);
      wr(TMR_OFS_MASK, 8'h01);
      wr(TMR_OFS_FLAG, 8'h07);
      wr(TMR_OFS_CTRL_B, {5'h00, TMR_CS_D1});
      wait_irq(0);
      wr(TMR_OFS_CTRL_B, 8'h00);
      rd(TMR_OFS_COUNT, q);
      check(q < 32'h00000010, 1'b1);
      rd(TMR_OFS_FLAG, q);
      check(q[TMR_FL_OVF], 1'b1);
      @(posedge clk_i);
      ovf_serviced_i <= 1'b1;
      @(posedge clk_i);
      ovf_serviced_i <= 1'b0;
      rd(TMR_OFS_FLAG, q);
      check(q[TMR_FL_OVF], 1'b0);
      // Clear-on-match with compare A as top, toggling output A
      wr(TMR_OFS_COUNT, 8'h00);
      wr(TMR_OFS_CMP_A, 8'h05);
      wr(TMR_OFS_MASK, 8'h02);
      wr(TMR_OFS_CTRL_A, 8'h42);
      wr(TMR_OFS_CTRL_B, {5'h00, TMR_CS_D1});
      wait_irq(1);
      w0 = wave_out_a_o;
      for (int i = 0; i < 6; i++) begin
         rd(TMR_OFS_COUNT, q);
         check(q <= 32'h00000005, 1'b1);
      end
      check(wave_out_a_o, !w0);
      wr(TMR_OFS_CTRL_B, 8'h00);
      wr(TMR_OFS_FLAG, 8'h02);
      rd(TMR_OFS_FLAG, q);
      check(q, 32'h00000000);
      // Divide by 8: about ten ticks in the timed window
      wr(TMR_OFS_CTRL_A, 8'h00);
      wr(TMR_OFS_COUNT, 8'h00);
      wr(TMR_OFS_CTRL_B, {5'h00, TMR_CS_D8});
      repeat (80) @(posedge clk_i);
      wr(TMR_OFS_CTRL_B, 8'h00);
      rd(TMR_OFS_COUNT, q);
      check(q >= 32'h00000009 && q <= 32'h0000000B, 1'b1);
      // External pin, rising edges then falling edges
      wr(TMR_OFS_COUNT, 8'h00);
      for (int m = 0; m < 2; m++) begin
         wr(TMR_OFS_CTRL_B, {5'h00, (m == 0) ? TMR_CS_EXTR : TMR_CS_EXTF});
         repeat (4) begin
            repeat (4) @(posedge clk_i);
            ext_count_pin_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            ext_count_pin_i <= 1'b0;
         end
         repeat (6) @(posedge clk_i);
         rd(TMR_OFS_COUNT, q);
         check(q, 32'(4 * (m + 1)));
      end
      end_of_test();
   end
endmodule : tb_top

// ---- tmr_core.sv ----
// 8-bit timer/counter, two compare units, Wishbone classic slave.
// Assumes a synchronous Wishbone master on clk_i; ext count pin async.
`timescale 1ns/1ps
module tmr_core
   import tmr_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        nrst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        ext_count_pin_i,
   input  wire logic        ovf_serviced_i,
   input  wire logic        match_a_serviced_i,
   input  wire logic        match_b_serviced_i,
   output logic             ovf_irq_o,
   output logic             match_a_irq_o,
   output logic             match_b_irq_o,
   output logic             wave_out_a_o,
   output logic             wave_out_b_o
);
   logic [7:0] timer_ctrl_a, next_timer_ctrl_a;
   logic [2:0] clock_source_sel, next_clock_source_sel;
   logic       waveform_mode_bit2, next_waveform_mode_bit2;
   logic [7:0] counter_value, next_counter_value;
   logic [7:0] cmp_act [2], next_cmp_act [2];
   logic [7:0] cmp_buf [2], next_cmp_buf [2];
   logic [2:0] timer_mask_reg, next_timer_mask_reg;
   logic [2:0] timer_flag_reg, next_timer_flag_reg;
   logic       timer_power_off, next_timer_power_off;
   logic [1:0] wave, next_wave;
   logic [1:0] match_pend, next_match_pend;
   logic       block_match, next_block_match;
   tmr_dir_t   dir, next_dir;
   logic [9:0] pre_cnt, next_pre_cnt;
   logic       ack, next_ack;
   logic [31:0] rdata, next_rdata;
   logic       pin_s1, pin_s2, pin_s3;

   logic [2:0] waveform_mode;
   logic       is_pwm, is_pcpwm, top_is_a, at_top, at_bottom;
   logic [7:0] top_val;
   logic       tick, pre_tick;
   logic [1:0] match;
   logic [1:0] oa [2];
   logic       wr, rd;
   logic [7:0] wbyte;
   logic [2:0] flag_set;

   assign waveform_mode = {waveform_mode_bit2,
                           timer_ctrl_a[TMR_CA_WGM1],
                           timer_ctrl_a[TMR_CA_WGM0]};
   assign is_pwm   = waveform_mode[0];
   assign is_pcpwm = (waveform_mode == TMR_WM_PCPWM) ||
                     (waveform_mode == TMR_WM_PCPWMA);
   assign top_is_a = waveform_mode[2] || (waveform_mode == TMR_WM_CTC);
   assign top_val  = top_is_a ? cmp_act[0] : TMR_MAX;
   assign at_top    = (counter_value == top_val);
   assign at_bottom = (counter_value == TMR_BOTTOM);
   assign oa[0] = timer_ctrl_a[TMR_CA_COMA +: 2];
   assign oa[1] = timer_ctrl_a[TMR_CA_COMB +: 2];
   assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !ack && wb_sel_i[0];
   assign rd    = wb_cyc_i && wb_stb_i && !wb_we_i && !ack;
   assign wbyte = wb_dat_i[7:0];

   // Pin sampled through two flops; edge seen on the third stage
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         pin_s3 <= 1'b0;
      end else begin
         pin_s1 <= ext_count_pin_i;
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   // Prescaler runs only while a source is selected and powered
   always_comb begin
      next_pre_cnt = pre_cnt + 10'h001;
      if (clock_source_sel == TMR_CS_OFF || timer_power_off) begin
         next_pre_cnt = 10'h000;
      end
      case (clock_source_sel)
         TMR_CS_D1:    pre_tick = 1'b1;
         TMR_CS_D8:    pre_tick = (pre_cnt[2:0] == TMR_PRE_D8[2:0]);
         TMR_CS_D64:   pre_tick = (pre_cnt[5:0] == TMR_PRE_D64[5:0]);
         TMR_CS_D256:  pre_tick = (pre_cnt[7:0] == TMR_PRE_D256[7:0]);
         TMR_CS_D1024: pre_tick = (pre_cnt == TMR_PRE_D1024);
         TMR_CS_EXTF:  pre_tick = pin_s3 && !pin_s2;
         TMR_CS_EXTR:  pre_tick = !pin_s3 && pin_s2;
         default:      pre_tick = 1'b0;
      endcase
      tick = pre_tick && !timer_power_off;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pre_cnt <= 10'h000;
      end else begin
         pre_cnt <= next_pre_cnt;
      end
   end

   // Compare, counter, flags, outputs and bus
   always_comb begin
      next_timer_ctrl_a       = timer_ctrl_a;
      next_clock_source_sel   = clock_source_sel;
      next_waveform_mode_bit2 = waveform_mode_bit2;
      next_counter_value      = counter_value;
      next_cmp_act            = cmp_act;
      next_cmp_buf            = cmp_buf;
      next_timer_mask_reg     = timer_mask_reg;
      next_timer_flag_reg     = timer_flag_reg;
      next_timer_power_off    = timer_power_off;
      next_wave               = wave;
      next_match_pend         = match_pend;
      next_block_match        = block_match;
      next_dir                = dir;
      next_ack                = rd || (wb_cyc_i && wb_stb_i && !ack);
      next_rdata              = 32'h0000_0000;
      flag_set                = 3'h0;

      for (int u = 0; u < 2; u++) begin
         match[u] = (counter_value == cmp_act[u]) && !block_match;
      end

      if (tick) begin
         next_block_match = 1'b0;
         // Flag lands one tick after equality
         for (int u = 0; u < 2; u++) begin
            if (match_pend[u]) begin
               flag_set[TMR_FL_MA + u] = 1'b1;
            end
            next_match_pend[u] = match[u];
            if (match[u] && oa[u] != TMR_OA_NONE) begin
               if (!is_pwm) begin
                  case (oa[u])
                     TMR_OA_TOGGLE: next_wave[u] = !wave[u];
                     TMR_OA_CLEAR:  next_wave[u] = 1'b0;
                     default:       next_wave[u] = 1'b1;
                  endcase
               end else begin
                  // PWM: action set means inverted output
                  next_wave[u] = (oa[u] == TMR_OA_SET) ^
                                 (is_pcpwm && dir == TMR_DIR_DOWN);
               end
            end
         end
         if (is_pwm && !is_pcpwm && at_top) begin
            for (int u = 0; u < 2; u++) begin
               if (oa[u][1]) begin
                  next_wave[u] = !oa[u][0];
               end
            end
         end
         // Count step
         if (is_pcpwm) begin
            if (dir == TMR_DIR_UP && at_top) begin
               next_dir = TMR_DIR_DOWN;
               next_counter_value = counter_value - 8'h01;
               next_cmp_act = cmp_buf;
            end else if (dir == TMR_DIR_DOWN && at_bottom) begin
               next_dir = TMR_DIR_UP;
               next_counter_value = counter_value + 8'h01;
               flag_set[TMR_FL_OVF] = 1'b1;
            end else if (dir == TMR_DIR_UP) begin
               next_counter_value = counter_value + 8'h01;
            end else begin
               next_counter_value = counter_value - 8'h01;
            end
         end else if (at_top && top_is_a) begin
            next_counter_value = TMR_BOTTOM;
            if (is_pwm) begin
               flag_set[TMR_FL_OVF] = 1'b1;
               next_cmp_act = cmp_buf;
            end
         end else begin
            next_dir = TMR_DIR_UP;
            next_counter_value = counter_value + 8'h01;
            if (counter_value == TMR_MAX) begin
               flag_set[TMR_FL_OVF] = 1'b1;
               if (is_pwm) begin
                  next_cmp_act = cmp_buf;
               end
            end
         end
      end

      if (!is_pwm) begin
         next_cmp_act = cmp_buf;
      end

      // Servicing or writing one clears; a set in the same cycle wins
      if (ovf_serviced_i) begin
         next_timer_flag_reg[TMR_FL_OVF] = 1'b0;
      end
      if (match_a_serviced_i) begin
         next_timer_flag_reg[TMR_FL_MA] = 1'b0;
      end
      if (match_b_serviced_i) begin
         next_timer_flag_reg[TMR_FL_MB] = 1'b0;
      end

      if (wr) begin
         case (wb_adr_i)
            TMR_OFS_CTRL_A: next_timer_ctrl_a = wbyte;
            TMR_OFS_CTRL_B: begin
               next_clock_source_sel   = wbyte[TMR_CB_CS +: 3];
               next_waveform_mode_bit2 = wbyte[TMR_CB_WGM2];
               for (int u = 0; u < 2; u++) begin
                  if (wbyte[TMR_CB_FOCA - u] && !is_pwm &&
                      oa[u] != TMR_OA_NONE) begin
                     case (oa[u])
                        TMR_OA_TOGGLE: next_wave[u] = !wave[u];
                        TMR_OA_CLEAR:  next_wave[u] = 1'b0;
                        default:       next_wave[u] = 1'b1;
                     endcase
                  end
               end
            end
            TMR_OFS_COUNT: begin
               next_counter_value = wbyte;
               next_block_match   = 1'b1;
               next_match_pend    = 2'b00;
            end
            TMR_OFS_CMP_A: next_cmp_buf[0] = wbyte;
            TMR_OFS_CMP_B: next_cmp_buf[1] = wbyte;
            TMR_OFS_MASK:  next_timer_mask_reg = wbyte[2:0];
            TMR_OFS_FLAG: begin
               for (int f = 0; f < 3; f++) begin
                  if (wbyte[f]) begin
                     next_timer_flag_reg[f] = 1'b0;
                  end
               end
            end
            TMR_OFS_POWER: next_timer_power_off = wbyte[0];
            default: ;
         endcase
      end
      // Sets merged last so an event beats any clear
      next_timer_flag_reg = next_timer_flag_reg | flag_set;

      if (rd) begin
         case (wb_adr_i)
            TMR_OFS_CTRL_A: next_rdata[7:0] = timer_ctrl_a;
            TMR_OFS_CTRL_B: next_rdata[7:0] = {4'h0, waveform_mode_bit2,
                                               clock_source_sel};
            TMR_OFS_COUNT:  next_rdata[7:0] = counter_value;
            TMR_OFS_CMP_A:  next_rdata[7:0] = cmp_buf[0];
            TMR_OFS_CMP_B:  next_rdata[7:0] = cmp_buf[1];
            TMR_OFS_MASK:   next_rdata[2:0] = timer_mask_reg;
            TMR_OFS_FLAG:   next_rdata[2:0] = timer_flag_reg;
            TMR_OFS_POWER:  next_rdata[0]   = timer_power_off;
            default:        next_rdata      = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         timer_ctrl_a       <= 8'h00;
         clock_source_sel   <= TMR_CS_OFF;
         waveform_mode_bit2 <= 1'b0;
         counter_value      <= TMR_BOTTOM;
         cmp_act            <= '{8'h00, 8'h00};
         cmp_buf            <= '{8'h00, 8'h00};
         timer_mask_reg     <= 3'h0;
         timer_flag_reg     <= 3'h0;
         timer_power_off    <= 1'b0;
         wave               <= 2'b00;
         match_pend         <= 2'b00;
         block_match        <= 1'b0;
         dir                <= TMR_DIR_UP;
         ack                <= 1'b0;
         rdata              <= 32'h0000_0000;
      end else begin
         timer_ctrl_a       <= next_timer_ctrl_a;
         clock_source_sel   <= next_clock_source_sel;
         waveform_mode_bit2 <= next_waveform_mode_bit2;
         counter_value      <= next_counter_value;
         cmp_act            <= next_cmp_act;
         cmp_buf            <= next_cmp_buf;
         timer_mask_reg     <= next_timer_mask_reg;
         timer_flag_reg     <= next_timer_flag_reg;
         timer_power_off    <= next_timer_power_off;
         wave               <= next_wave;
         match_pend         <= next_match_pend;
         block_match        <= next_block_match;
         dir                <= next_dir;
         ack                <= next_ack;
         rdata              <= next_rdata;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
   assign ovf_irq_o = timer_flag_reg[TMR_FL_OVF] &&
                      timer_mask_reg[TMR_FL_OVF];
   assign match_a_irq_o = timer_flag_reg[TMR_FL_MA] &&
                          timer_mask_reg[TMR_FL_MA];
   assign match_b_irq_o = timer_flag_reg[TMR_FL_MB] &&
                          timer_mask_reg[TMR_FL_MB];
   assign wave_out_a_o = wave[0];
   assign wave_out_b_o = wave[1];

   chk_stop_holds: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (clock_source_sel == TMR_CS_OFF && !wr) |=> $stable(counter_value))
      else $error("counter moved with no clock source");
   chk_write_wins: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr && wb_adr_i == TMR_OFS_COUNT) |=> counter_value == $past(wbyte))
      else $error("counter write lost");
   chk_irq_gate: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (tick && match_pend[1] && timer_mask_reg[TMR_FL_MB] && !wr) |=>
      match_b_irq_o)
      else $error("match b request not raised");
   chk_norm_wrap: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (tick && !wr && waveform_mode == TMR_WM_NORMAL &&
       counter_value == TMR_MAX) |=> (counter_value == TMR_BOTTOM &&
       timer_flag_reg[TMR_FL_OVF]))
      else $error("normal mode wrap wrong");
   chk_ctc_clear: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (tick && !wr && waveform_mode == TMR_WM_CTC && at_top) |=>
      counter_value == TMR_BOTTOM)
      else $error("clear on match failed");
   sequence s_match_tick;
      tick && !wr && match[0];
   endsequence
   sequence s_next_tick;
      tick;
   endsequence
   chk_flag_delay: assert property (@(posedge clk_i) disable iff (!nrst_i)
      s_match_tick ##1 s_next_tick |=> timer_flag_reg[TMR_FL_MA])
      else $error("match flag not set one tick later");
   chk_block_match: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (wr && wb_adr_i == TMR_OFS_COUNT) |=> !match[0] && !match[1])
      else $error("match not blocked after count write");
   chk_no_action: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (oa[0] == TMR_OA_NONE && !(is_pwm && !is_pcpwm)) |=>
      ($past(oa[0]) != TMR_OA_NONE || $stable(wave[0])))
      else $error("output changed with no action");
   chk_direct_cmp: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (!is_pwm && wr && wb_adr_i == TMR_OFS_CMP_B) |=>
      ##1 (cmp_act[1] == $past(wbyte, 2) || is_pwm))
      else $error("direct compare write missing");
endmodule : tmr_core

// ---- tmr_pkg.sv ----
// Package for the 8-bit dual compare timer.
// Shared by the timer core; bus is classic Wishbone, 32-bit data.
package tmr_pkg;
   localparam logic [7:0] TMR_BOTTOM      = 8'h00;
   localparam logic [7:0] TMR_MAX         = 8'hFF;
   // Register byte offsets
   localparam logic [7:0] TMR_OFS_CTRL_A  = 8'h00;
   localparam logic [7:0] TMR_OFS_CTRL_B  = 8'h04;
   localparam logic [7:0] TMR_OFS_COUNT   = 8'h08;
   localparam logic [7:0] TMR_OFS_CMP_A   = 8'h0C;
   localparam logic [7:0] TMR_OFS_CMP_B   = 8'h10;
   localparam logic [7:0] TMR_OFS_MASK    = 8'h14;
   localparam logic [7:0] TMR_OFS_FLAG    = 8'h18;
   localparam logic [7:0] TMR_OFS_POWER   = 8'h1C;
   // timer_ctrl_a fields
   localparam int TMR_CA_WGM0 = 0;
   localparam int TMR_CA_WGM1 = 1;
   localparam int TMR_CA_COMB = 4;
   localparam int TMR_CA_COMA = 6;
   // timer_ctrl_b fields
   localparam int TMR_CB_CS   = 0;
   localparam int TMR_CB_WGM2 = 3;
   localparam int TMR_CB_FOCB = 6;
   localparam int TMR_CB_FOCA = 7;
   // Flag and mask bit positions
   localparam int TMR_FL_OVF  = 0;
   localparam int TMR_FL_MA   = 1;
   localparam int TMR_FL_MB   = 2;
   // Waveform modes
   localparam logic [2:0] TMR_WM_NORMAL = 3'h0;
   localparam logic [2:0] TMR_WM_PCPWM  = 3'h1;
   localparam logic [2:0] TMR_WM_CTC    = 3'h2;
   localparam logic [2:0] TMR_WM_FAST   = 3'h3;
   localparam logic [2:0] TMR_WM_PCPWMA = 3'h5;
   localparam logic [2:0] TMR_WM_FASTA  = 3'h7;
   // Clock source select
   localparam logic [2:0] TMR_CS_OFF    = 3'h0;
   localparam logic [2:0] TMR_CS_D1     = 3'h1;
   localparam logic [2:0] TMR_CS_D8     = 3'h2;
   localparam logic [2:0] TMR_CS_D64    = 3'h3;
   localparam logic [2:0] TMR_CS_D256   = 3'h4;
   localparam logic [2:0] TMR_CS_D1024  = 3'h5;
   localparam logic [2:0] TMR_CS_EXTF   = 3'h6;
   localparam logic [2:0] TMR_CS_EXTR   = 3'h7;
   // Output actions
   localparam logic [1:0] TMR_OA_NONE   = 2'h0;
   localparam logic [1:0] TMR_OA_TOGGLE = 2'h1;
   localparam logic [1:0] TMR_OA_CLEAR  = 2'h2;
   localparam logic [1:0] TMR_OA_SET    = 2'h3;
   localparam logic [9:0] TMR_PRE_D8    = 10'h007;
   localparam logic [9:0] TMR_PRE_D64   = 10'h03F;
   localparam logic [9:0] TMR_PRE_D256  = 10'h0FF;
   localparam logic [9:0] TMR_PRE_D1024 = 10'h3FF;
   typedef enum logic [1:0] {
      TMR_DIR_UP   = 2'b01,
      TMR_DIR_DOWN = 2'b10
   } tmr_dir_t;
endpackage : tmr_pkg
